/* File: include/ots_pkg.sv */
package ots_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_THR_GAS = 8'h04;
  localparam logic [7:0] REG_THR_OIL = 8'h08;
  localparam logic [7:0] REG_LOCK_S = 8'h0c;
  localparam logic [7:0] REG_TAU = 8'h10;
  localparam logic [7:0] REG_SETPT = 8'h14;
  localparam logic [7:0] REG_MIN = 8'h18;
  localparam logic [7:0] REG_MIN_LOW = 8'h1c;
  localparam logic [7:0] REG_AMBIENT = 8'h20;
  localparam logic [7:0] REG_STATUS = 8'h24;
  localparam int CTRL_FUEL_BIT = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Times in their own units
  localparam int CLK_HZ = 125_000_000;
  localparam int WARM_MIN = 10;
  localparam int SCHED_H = 23;
  localparam int FORCE_H = 24;
  localparam logic [31:0] O2LOW_S = 32'h3;
  // Oxygen and manipulated variable in 0.1 % units, load in whole percent
  localparam logic [7:0] LOAD_HYST = 8'h05;
  localparam logic [15:0] MV_INIT_OFS = 16'h0025;
  localparam logic [15:0] BOOST_SMALL = 16'h001e;
  localparam logic [15:0] BOOST_LARGE = 16'h0032;
  localparam logic [15:0] AMB_TOL = 16'h0014;
  localparam logic [15:0] AMB_RESET = 16'h00d1;
  localparam logic [15:0] RES_MIN = 16'h0005;
  localparam logic [15:0] RES_MAX = 16'h0096;
  localparam logic [1:0] TEST_TRIES = 2'h3;
  localparam int LAG_FRAC = 8;
  typedef enum logic [2:0] {
    MAN_DEACT, MONITOR_ONLY_MODE, TRIM_AND_MONITOR_MODE,
    START_WITH_AUTO_DEACTIVATION, AUTO_OFF
  } ots_trim_supervision_mode_t;
endpackage : ots_pkg

/* File: design/ots_supervisor.sv */
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
// Overview of operation
// - Below load threshold trimming off; re-enable only 5 points above threshold.
// - Separate gas and oil load thresholds, selected by active fuel.
// - Monitor modes block startup until sensor reports operating temperature.
// - Auto-deactivation mode starts at once; trims after hot sensor and passed test.
// - After reaching temperature, wait 10 more minutes before fully hot.
// - Monitor modes start when fully hot; trim-and-monitor mode trims when lock interval expires.
// - Start locked; lock timer runs only at constant load, length from plant delay.
// - At lock end, manipulated variable is theoretical value plus 3.7 %.
// - Any load change locks the controller and holds the manipulated variable.
// - Release lock once load stationary longer than the lock interval.
// - Air boosts stay active during lock interval and normal trimming.
// - Oxygen past half span adds 3 %, past three quarters 5 %.
// - Setpoint and minimum pass a first-order lag before comparisons.
// - Oxygen below lagged or smallest minimum over 3 s is a fault.
// - Monitor modes: oxygen fault gives shutdown, restart if permitted, else lockout.
// - Auto-deactivation mode: oxygen fault turns trimming off until re-enabled.
// - Cell aged when internal resistance below 5 or above 150 ohms.
// - Sensor test every 23 hours at first steady oxygen moment.
// - At 24 hours freeze load for the test; standby tests at startup, 3 tries.
// - No test while trim off; failure shuts down or disables trimming by mode.
// - After prepurge, oxygen off ambient reference by over 2 points is a fault.
// - Ambient fault skipped when off; shutdown or disable by mode.
// - Auto deactivation sets mode to auto-off and holds error until mode rewritten.
module ots_supervisor
  import ots_pkg::*;
#(
  parameter int SEC_CYCLES = CLK_HZ,
  parameter int WARM_S = WARM_MIN * 60,
  parameter int SCHED_S = SCHED_H * 3600,
  parameter int FORCE_S = FORCE_H * 3600
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Register bus read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Plant inputs
  input wire logic [7:0] load_pct,
  input wire logic [15:0] o2_meas,
  input wire logic sensor_hot,
  input wire logic [15:0] cell_internal_resistance,
  input wire logic prepurge_end,
  input wire logic standby,
  input wire logic restart_permitted,
  input wire logic [15:0] mv_theoretical,
  input wire logic [15:0] mv_controller,
  // Supervisor outputs
  output logic start_permit,
  output logic trim_enable,
  output logic trim_locked,
  output logic [15:0] mv_out,
  output logic safety_shutdown,
  output logic lockout,
  output logic load_freeze,
  output logic sensor_test_run,
  output logic auto_deact_error
);
  // Saturating add, used for every correction of the manipulated variable
  function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[16] ? 16'hffff : s[15:0];
  endfunction : sat_add
  // First-order lag step with 8 fraction bits
  function automatic logic [23:0] pt1(input logic [23:0] y, input logic [15:0] x, input logic [3:0] sh);
    logic signed [24:0] d;
    d = $signed({1'b0, x, 8'h00}) - $signed({1'b0, y});
    pt1 = y + 24'(d >>> sh);
  endfunction : pt1
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      o[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
    end
    merge = o;
  endfunction : merge

  ots_trim_supervision_mode_t mode_q;
  logic fuel_oil_q;
  logic [7:0] thr_gas_q, thr_oil_q;
  logic [15:0] lock_s_q, setpt_q, min_q, min_low_q, ambient_q;
  logic [3:0] tau_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, aw_have_q, w_have_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, wdata_q;
  logic [7:0] awaddr_q;
  logic [3:0] wstrb_q;
  logic [31:0] tick_cnt_q, warm_cnt_q, lock_cnt_q, low_cnt_q, sched_cnt_q;
  logic sec_tick, full_hot_q, locked_q, below_q, trim_en_q, start_q, shut_q, lockout_q;
  logic freeze_q, test_run_q, test_ok_q, test_fail_q, o2_fault_q, amb_fault_q, err_q;
  logic [7:0] load_prev_q;
  logic [15:0] mv_q;
  logic [23:0] sp_lag_q, min_lag_q;
  logic [1:0] boost_q, tries_q;

  // Outputs straight from flops
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign start_permit = start_q;
  assign trim_enable = trim_en_q;
  assign trim_locked = locked_q;
  assign mv_out = mv_q;
  assign safety_shutdown = shut_q;
  assign lockout = lockout_q;
  assign load_freeze = freeze_q;
  assign sensor_test_run = test_run_q;
  assign auto_deact_error = err_q;

  // Mode decode and threshold selection
  wire mon_mode = (mode_q == MONITOR_ONLY_MODE) || (mode_q == TRIM_AND_MONITOR_MODE);
  wire auto_mode = (mode_q == START_WITH_AUTO_DEACTIVATION);
  wire active = mon_mode || auto_mode;
  wire trim_mode = (mode_q == TRIM_AND_MONITOR_MODE) || auto_mode;
  wire [7:0] thr = fuel_oil_q ? thr_oil_q : thr_gas_q;
  wire load_chg = (load_pct != load_prev_q);
  wire lock_done = locked_q && !load_chg && (lock_cnt_q > {16'h0000, lock_s_q});
  wire go_below = (load_pct < thr);
  wire go_above = ({1'b0, load_pct} >= ({1'b0, thr} + {1'b0, LOAD_HYST}));
  wire auto_ready = full_hot_q && test_ok_q;
  // Lagged comparisons for boosts and monitor
  wire [15:0] sp_lag = sp_lag_q[23:LAG_FRAC];
  wire [15:0] min_lag = min_lag_q[23:LAG_FRAC];
  wire [17:0] span = (sp_lag > min_lag) ? {2'b00, sp_lag - min_lag} : 18'h0;
  wire [17:0] defc = (sp_lag > o2_meas) ? {2'b00, sp_lag - o2_meas} : 18'h0;
  wire lvl2 = (span != 18'h0) && ({defc[15:0], 2'b00} > (span + {span[16:0], 1'b0}));
  wire lvl1 = (span != 18'h0) && ({defc[16:0], 1'b0} > span);
  wire [1:0] lvl = lvl2 ? 2'h2 : (lvl1 ? 2'h1 : 2'h0);
  wire boosting = trim_mode && (lvl > boost_q);
  wire [15:0] boost_add = (lvl == 2'h2) ? ((boost_q == 2'h1) ? BOOST_LARGE - BOOST_SMALL : BOOST_LARGE)
                                        : BOOST_SMALL;
  wire o2_low = (o2_meas < min_lag) || (o2_meas < min_low_q);
  wire o2_trip = active && o2_low && sec_tick && (low_cnt_q >= O2LOW_S);
  // Sensor test and ambient check
  wire test_due = trim_mode && (sched_cnt_q >= SCHED_S);
  wire steady = prepurge_end || (!locked_q && !standby);
  wire test_go = test_due && (steady || freeze_q);
  wire aged = (cell_internal_resistance < RES_MIN) || (cell_internal_resistance > RES_MAX);
  wire test_bad = test_go && aged && (tries_q == TEST_TRIES - 2'h1);
  wire [15:0] amb_diff = (o2_meas > ambient_q) ? o2_meas - ambient_q : ambient_q - o2_meas;
  wire amb_bad = prepurge_end && active && (amb_diff > AMB_TOL);
  wire fault = o2_trip || test_bad || amb_bad;
  // Bus decode
  wire aw_hs = awvalid && awready_q;
  wire w_hs = wvalid && wready_q;
  wire do_wr = aw_have_q && w_have_q && !bvalid_q;
  wire wr_map = (awaddr_q <= REG_AMBIENT) && (awaddr_q[1:0] == 2'h0);
  wire [31:0] wv = merge(32'h0, wdata_q, wstrb_q);
  wire [31:0] status = {16'h0, 3'h0, err_q, lockout_q, amb_fault_q, o2_fault_q, test_fail_q,
                        test_ok_q, full_hot_q, locked_q, below_q, trim_en_q, mode_q};
  wire rd_map = (araddr <= REG_STATUS) && (araddr[1:0] == 2'h0);
  wire [31:0] rd_val = (araddr == REG_CTRL) ? {27'h0, fuel_oil_q, 1'b0, mode_q} :
                       (araddr == REG_THR_GAS) ? {24'h0, thr_gas_q} :
                       (araddr == REG_THR_OIL) ? {24'h0, thr_oil_q} :
                       (araddr == REG_LOCK_S) ? {16'h0, lock_s_q} :
                       (araddr == REG_TAU) ? {28'h0, tau_q} :
                       (araddr == REG_SETPT) ? {16'h0, setpt_q} :
                       (araddr == REG_MIN) ? {16'h0, min_q} :
                       (araddr == REG_MIN_LOW) ? {16'h0, min_low_q} :
                       (araddr == REG_AMBIENT) ? {16'h0, ambient_q} :
                       (araddr == REG_STATUS) ? status : 32'h0;

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q <= awaddr;
      end
      if (w_hs) begin
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR; // Status is read only
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Read channel, one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Configuration; auto deactivation overrides a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= MAN_DEACT;
      fuel_oil_q <= 1'b0;
      thr_gas_q <= 8'h00;
      thr_oil_q <= 8'h00;
      lock_s_q <= 16'h0000;
      tau_q <= 4'h0;
      setpt_q <= 16'h0000;
      min_q <= 16'h0000;
      min_low_q <= 16'h0000;
      ambient_q <= AMB_RESET;
      err_q <= 1'b0;
    end else begin
      if (do_wr && wr_map) begin
        case (awaddr_q)
          REG_CTRL: begin
            if (wv[2:0] <= 3'(AUTO_OFF)) begin
              mode_q <= ots_trim_supervision_mode_t'(wv[2:0]);
              err_q <= 1'b0;
            end
            fuel_oil_q <= wv[CTRL_FUEL_BIT];
          end
          REG_THR_GAS: thr_gas_q <= wv[7:0];
          REG_THR_OIL: thr_oil_q <= wv[7:0];
          REG_LOCK_S: lock_s_q <= wv[15:0];
          REG_TAU: tau_q <= wv[3:0];
          REG_SETPT: setpt_q <= wv[15:0];
          REG_MIN: min_q <= wv[15:0];
          REG_MIN_LOW: min_low_q <= wv[15:0];
          REG_AMBIENT: ambient_q <= wv[15:0];
          default: ;
        endcase
      end
      if (auto_mode && fault) begin
        mode_q <= AUTO_OFF;
        err_q <= 1'b1;
      end
    end
  end

  // Second tick and sensor warm-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= 32'h0;
      warm_cnt_q <= 32'h0;
      full_hot_q <= 1'b0;
    end else begin
      tick_cnt_q <= sec_tick ? 32'h0 : tick_cnt_q + 32'h1;
      if (!sensor_hot) begin
        warm_cnt_q <= 32'h0;
        full_hot_q <= 1'b0;
      end else if (warm_cnt_q >= WARM_S) begin
        full_hot_q <= 1'b1;
      end else if (sec_tick) begin
        warm_cnt_q <= warm_cnt_q + 32'h1;
      end
    end
  end
  assign sec_tick = (tick_cnt_q == SEC_CYCLES - 1);

  // Lock interval, load hysteresis and trim enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_prev_q <= 8'h00;
      locked_q <= 1'b1;
      lock_cnt_q <= 32'h0;
      below_q <= 1'b1;
      trim_en_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      load_prev_q <= load_pct;
      if (load_chg || (below_q && go_above)) begin
        locked_q <= 1'b1;
        lock_cnt_q <= 32'h0;
      end else if (lock_done) begin
        locked_q <= 1'b0;
      end else if (locked_q && sec_tick && !freeze_q) begin
        lock_cnt_q <= lock_cnt_q + 32'h1;
      end
      if (go_below) begin
        below_q <= 1'b1;
      end else if (go_above) begin
        below_q <= 1'b0;
      end
      // Load change drops trimming at once, so the controller output cannot reach mv after the lock
      trim_en_q <= trim_mode && !go_below && !below_q && !locked_q && !load_chg && !lockout_q
                   && (!auto_mode || auto_ready) && !fault;
      start_q <= !lockout_q && !shut_q && (!mon_mode || (sensor_hot && full_hot_q));
    end
  end

  // Manipulated variable: init at lock end, hold while locked, boosts in trim modes even while locked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mv_q <= 16'h0000;
      boost_q <= 2'h0;
    end else begin
      if (boosting) begin
        mv_q <= sat_add(mv_q, boost_add);
      end else if (lock_done) begin
        mv_q <= sat_add(mv_theoretical, MV_INIT_OFS);
      end else if (trim_en_q) begin
        mv_q <= mv_controller;
      end
      boost_q <= (lvl == 2'h0) ? 2'h0 : (boosting ? lvl : boost_q);
    end
  end

  // Lagged setpoint and minimum, updated each second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_lag_q <= 24'h0;
      min_lag_q <= 24'h0;
    end else if (sec_tick) begin
      sp_lag_q <= pt1(sp_lag_q, setpt_q, tau_q);
      min_lag_q <= pt1(min_lag_q, min_q, tau_q);
    end
  end

  // Oxygen low, sensor test and ambient check with the reaction per mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_q <= 32'h0;
      sched_cnt_q <= 32'hffffffff; // First test due at once
      tries_q <= 2'h0;
      test_run_q <= 1'b0;
      test_ok_q <= 1'b0;
      test_fail_q <= 1'b0;
      freeze_q <= 1'b0;
      o2_fault_q <= 1'b0;
      amb_fault_q <= 1'b0;
      shut_q <= 1'b0;
      lockout_q <= 1'b0;
    end else begin
      if (!o2_low || !active) begin
        low_cnt_q <= 32'h0;
      end else if (sec_tick && (low_cnt_q < O2LOW_S)) begin
        // Saturates, so every later tick of a long excursion trips again
        low_cnt_q <= low_cnt_q + 32'h1;
      end
      o2_fault_q <= o2_fault_q || o2_trip;
      amb_fault_q <= amb_fault_q || amb_bad;
      test_run_q <= test_go;
      if (test_go && !aged) begin
        sched_cnt_q <= 32'h0;
        tries_q <= 2'h0;
        test_ok_q <= 1'b1;
        freeze_q <= 1'b0;
      end else if (test_go) begin
        tries_q <= test_bad ? 2'h0 : tries_q + 2'h1;
        sched_cnt_q <= test_bad ? 32'h0 : sched_cnt_q;
        test_fail_q <= test_fail_q || test_bad;
        freeze_q <= 1'b0;
      end else if (!trim_mode) begin
        freeze_q <= 1'b0;
      end else begin
        if (sec_tick && sched_cnt_q != 32'hffffffff) begin
          sched_cnt_q <= sched_cnt_q + 32'h1;
        end
        freeze_q <= !standby && (sched_cnt_q >= FORCE_S);
      end
      shut_q <= mon_mode && fault && restart_permitted;
      lockout_q <= lockout_q || (mon_mode && fault && !restart_permitted);
    end
  end

  // Checks
  AST_LOCK_ON_CHANGE: assert property (@(posedge aclk) disable iff (!aresetn)
    load_chg |=> locked_q && !trim_en_q) else $error("load change did not lock");
  AST_MV_HELD: assert property (@(posedge aclk) disable iff (!aresetn)
    locked_q && !boosting && !lock_done |=> mv_q == $past(mv_q)) else $error("mv moved while locked");
  AST_START_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    mon_mode && !full_hot_q |=> !start_q) else $error("start while sensor cold");
  AST_AUTO_START: assert property (@(posedge aclk) disable iff (!aresetn)
    auto_mode && !lockout_q && !shut_q && !fault |=> start_q) else $error("auto mode start held");
  AST_INIT_MV: assert property (@(posedge aclk) disable iff (!aresetn)
    lock_done && !boosting |=> mv_q == $past(mv_theoretical) + MV_INIT_OFS) else $error("bad init mv");
  AST_BELOW_THR: assert property (@(posedge aclk) disable iff (!aresetn)
    go_below |=> !trim_en_q ##1 !trim_en_q) else $error("trim on below threshold");
  AST_AMB_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)
    amb_bad |=> amb_fault_q) else $error("ambient offset missed");
  AST_AUTO_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    auto_mode && fault |=> mode_q == AUTO_OFF && err_q && !trim_en_q) else $error("no auto deactivation");
  AST_MON_SHUT: assert property (@(posedge aclk) disable iff (!aresetn)
    mon_mode && fault |=> (shut_q || lockout_q) ##1 !start_q) else $error("no shutdown on fault");
  AST_O2_LOW_WAIT: assert property (@(posedge aclk) disable iff (!aresetn)
    o2_trip |-> low_cnt_q == O2LOW_S) else $error("oxygen fault too early");
  COV_RELEASE: cover property (@(posedge aclk) disable iff (!aresetn) lock_done ##1 !locked_q);
  COV_BOOST_BIG: cover property (@(posedge aclk) disable iff (!aresetn) boosting && lvl == 2'h2);
  COV_TEST: cover property (@(posedge aclk) disable iff (!aresetn) test_go && !aged);
endmodule : ots_supervisor

/* File: verif/ots_plant_model.sv */
`timescale 1ns/1ns
// Stand-in for the burner sequencer and the oxygen sensor module
module ots_plant_model #(
  parameter int HEAT_CYC = 12,
  parameter int PURGE_CYC = 16
) (
  // Clock
  input wire logic aclk,
  // Requests from the bench
  input wire logic heat_req,
  input wire logic purge_req,
  // Towards the supervisor
  output logic sensor_hot,
  output logic prepurge_end
);
  int heat_n = 0;
  int purge_n = 0;
  // Sensor heats slowly; hot flag drops at once when heating stops
  always @(posedge aclk) begin
    heat_n <= heat_req ? heat_n + 1 : 0;
    sensor_hot <= heat_req && heat_n >= HEAT_CYC;
  end
  // Full purge length before the end pulse, so the flueways are flushed
  always @(posedge aclk) begin
    purge_n <= purge_req ? purge_n + 1 : 0;
    prepurge_end <= purge_req && purge_n == PURGE_CYC;
  end
endmodule : ots_plant_model

/* File: verif/ots_supervisor_bench.sv */
`timescale 1ns/1ns
module ots_supervisor_bench;
  import ots_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, load_pct = 8'h32;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  // Readies held high throughout: legal, and avoids re-driving between calls
  logic bready = 1'b1, rready = 1'b1;
  logic [31:0] wdata = 32'h0;
  logic [15:0] o2_meas = 16'h0050, mv_theoretical = 16'h0100, mv_controller = 16'h0130;
  logic [15:0] cell_internal_resistance = 16'h0032;
  logic restart_permitted = 1'b1, heat_req = 1'b0, purge_req = 1'b0, shut_seen = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sensor_hot, prepurge_end;
  logic start_permit, trim_enable, trim_locked, safety_shutdown, lockout, load_freeze;
  logic sensor_test_run, auto_deact_error;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [15:0] mv_out, mv_hold;
  int err_count = 0, check_count = 0, cyc = 0, i;

  // Short time base: 10 cycles a second
  ots_supervisor #(.SEC_CYCLES(10), .WARM_S(3), .SCHED_S(20), .FORCE_S(30)) ots_supervisor_inst (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .load_pct, .o2_meas, .sensor_hot, .cell_internal_resistance, .prepurge_end,
    .standby(1'b0), .restart_permitted, .mv_theoretical, .mv_controller, .start_permit,
    .trim_enable, .trim_locked, .mv_out, .safety_shutdown, .lockout, .load_freeze,
    .sensor_test_run, .auto_deact_error);
  ots_plant_model ots_plant_model_inst (.aclk, .heat_req, .purge_req, .sensor_hot, .prepurge_end);

  always #4 aclk = ~aclk;
  // Pulse catcher and hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (safety_shutdown === 1'b1) shut_seen <= 1'b1;
    if (cyc == 20000) begin
      err_count++;
      $display("unexpected at %0t: run too long", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: response %h want %h", $time, got, exp);
    end
  endtask : chk_resp

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
  endtask : rd_reg

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task automatic wrap_up;
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  initial begin
    tick(5);
    aresetn <= 1'b1;
    tick(1);
    chk(trim_locked, 1'b1, "locked at start");
    rd_reg(REG_AMBIENT);
    chk(rd, 32'h000000d1, "ambient reset");
    rd_reg(8'h3c);
    chk_resp(resp, RESP_SLVERR);
    wr(REG_STATUS, 32'h0);
    chk_resp(resp, RESP_SLVERR);
    wr(REG_THR_GAS, 32'h14);
    wr(REG_LOCK_S, 32'h2);
    wr(REG_MIN, 32'h28);
    wr(REG_MIN_LOW, 32'h28);
    wr(REG_SETPT, 32'h32);
    wr(REG_CTRL, 32'h1);
    chk_resp(resp, RESP_OKAY);
    // Startup gating on a cold, then warming sensor
    tick(20);
    chk(start_permit, 1'b0, "cold start");
    heat_req <= 1'b1;
    for (i = 0; i < 40 && sensor_hot !== 1'b1; i++) tick(1);
    tick(10);
    chk(start_permit, 1'b0, "warm-up hold");
    for (i = 0; i < 100 && start_permit !== 1'b1; i++) tick(1);
    chk(start_permit, 1'b1, "fully hot start");
    // Lock on load change, hold, then pre-offset release
    wr(REG_CTRL, 32'h2);
    load_pct <= 8'h33;
    tick(2);
    mv_hold = mv_out;
    tick(3);
    chk(trim_locked, 1'b1, "load change lock");
    chk(mv_out, mv_hold, "mv held");
    for (i = 0; i < 300 && trim_locked !== 1'b0; i++) tick(1);
    chk(mv_out, 16'h0125, "initial mv");
    load_pct <= 8'h34;
    mv_theoretical <= 16'h0200;
    tick(25);
    load_pct <= 8'h35;
    tick(15);
    chk(trim_locked, 1'b1, "lock restarted");
    for (i = 0; i < 300 && trim_locked !== 1'b0; i++) tick(1);
    chk(mv_out, 16'h0225, "reinit mv");
    tick(3);
    chk(trim_enable, 1'b1, "trim after lock");
    mv_controller <= 16'h0140;
    tick(2);
    chk(mv_out, 16'h0140, "trim mv");
    // Load threshold with hysteresis, then the oil threshold
    load_pct <= 8'h12;
    tick(3);
    chk(trim_enable, 1'b0, "below threshold");
    load_pct <= 8'h18;
    tick(50);
    chk(trim_enable, 1'b0, "inside hysteresis");
    load_pct <= 8'h19;
    for (i = 0; i < 300 && trim_enable !== 1'b1; i++) tick(1);
    chk(trim_enable, 1'b1, "above hysteresis");
    wr(REG_THR_OIL, 32'h3c);
    wr(REG_CTRL, 32'h12);
    tick(3);
    chk(trim_enable, 1'b0, "oil threshold");
    // Low oxygen: shutdown with restart allowed
    wr(REG_CTRL, 32'h2);
    o2_meas <= 16'h0010;
    tick(20);
    chk(shut_seen, 1'b0, "no early fault");
    chk(mv_out, 16'h0172, "air boost during lock");
    for (i = 0; i < 80 && shut_seen !== 1'b1; i++) tick(1);
    chk(shut_seen, 1'b1, "oxygen shutdown");
    chk(lockout, 1'b0, "restart allowed");
    // Ambient offset after prepurge in auto-deactivation mode
    o2_meas <= 16'h00b0;
    wr(REG_CTRL, 32'h3);
    purge_req <= 1'b1;
    for (i = 0; i < 60 && auto_deact_error !== 1'b1; i++) tick(1);
    chk(auto_deact_error, 1'b1, "ambient fault");
    purge_req <= 1'b0;
    rd_reg(REG_STATUS);
    chk(rd[2:0], 3'h4, "auto-off mode");
    chk(trim_enable, 1'b0, "trim off");
    // Mode rewrite to monitor mode clears the error
    wr(REG_CTRL, 32'h1);
    tick(1);
    chk(auto_deact_error, 1'b0, "error cleared");
    // Aged cell in auto-deactivation mode: third failed try switches trimming off; then low oxygen without restart locks out
    cell_internal_resistance <= 16'h00c8;
    wr(REG_CTRL, 32'h3);
    for (i = 0; i < 300 && auto_deact_error !== 1'b1; i++) tick(1);
    rd_reg(REG_STATUS);
    chk(rd[8], 1'b1, "aged cell");
    cell_internal_resistance <= 16'h0032;
    wr(REG_CTRL, 32'h1);
    restart_permitted <= 1'b0;
    o2_meas <= 16'h0010;
    for (i = 0; i < 80 && lockout !== 1'b1; i++) tick(1);
    chk(lockout, 1'b1, "lockout");
    wrap_up();
  end
endmodule : ots_supervisor_bench
